// >>> scm_cfg.svh
// constants for the sensor correction datapath
`ifndef SCM_CFG_SVH
`define SCM_CFG_SVH

`define SCM_WORD_W     18
`define SCM_FRAC       15
`define SCM_ONE        18'h08000
`define SCM_ZERO       18'h00000
`define SCM_MAX18      18'h1FFFF
`define SCM_MIN18      18'h20000
`define SCM_COEF_MAX   18'h1FFFF
`define SCM_COEF_MIN   18'h20001
`define SCM_TREF_MAX   18'h0FFFF
`define SCM_TREF_MIN   18'h30001
`define SCM_U16_MAX    18'h0FFFF
`define SCM_STEP_LAST  5'h13
`define SCM_STEP_TEMP  5'h0E
`define SCM_CURVE_PAR  1'b0
`define SCM_CURVE_S    1'b1
`define SCM_STAT_PAD   7'h00

`endif

// >>> scm_core.sv
// sequential bridge and temperature correction datapath
`timescale 1ns/1ps
`default_nettype none
`include "scm_cfg.svh"
// Functional notes
// - curve select zero uses parabolic bridge equations
// - curve select one uses S-shape, absolute term
// - temperature delta saturates, reference limited to FFFF
// - bridge coefficients held within plus-minus 1FFFF
// - raw bridge input within plus-minus 1FFFF
// - gain factor built from drift terms, saturated
// - offset term built from drift terms, saturated
// - parabolic intermediate clamped zero to 2^17-1
// - final bridge clamped to unsigned 16 bits
// - every step saturates and flags overflow
// - temperature second order always parabolic
// - intermediate temperature clamped zero to 2^17-1
// - corrected temperature clamped to 16 bits
// - saturation still gives output, status bit0
module scm_core (
    input  wire logic               sys_clk,
    input  wire logic               sys_rst,
    input  wire logic               start,
    input  wire logic               curve_shape_select,
    input  wire scm_pkg::scm_word_t raw_bridge_reading,
    input  wire scm_pkg::scm_word_t raw_temperature,
    input  wire scm_pkg::scm_word_t calibration_reference_temp,
    input  wire scm_pkg::scm_word_t bridge_gain,
    input  wire scm_pkg::scm_word_t bridge_offset,
    input  wire scm_pkg::scm_word_t gain_drift,
    input  wire scm_pkg::scm_word_t offset_drift,
    input  wire scm_pkg::scm_word_t second_order_gain_drift,
    input  wire scm_pkg::scm_word_t second_order_offset_drift,
    input  wire scm_pkg::scm_word_t second_order_bridge_term,
    input  wire scm_pkg::scm_word_t temp_gain,
    input  wire scm_pkg::scm_word_t temp_offset,
    input  wire scm_pkg::scm_word_t temperature_second_order_term,
    output logic                    busy,
    output logic                    done,
    output logic [15:0]             bridge_result,
    output logic [15:0]             temp_result,
    output logic [7:0]              bridge_status,
    output logic [7:0]              temp_status
);
    import scm_pkg::*;

    localparam int N_IN  = 13;
    localparam int N_TMP = 20;

    // clamp a word into [lo, hi], both given as signed words
    function automatic scm_word_t clamp_word(input scm_word_t v,
                                             input scm_word_t lo,
                                             input scm_word_t hi);
        clamp_word = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction

    scm_state_t      state;
    scm_state_t      next_state;
    logic [4:0]      step;
    logic [4:0]      next_step;
    logic            curve;
    logic            bflag;
    logic            tflag;
    scm_word_t       in_word [0:N_IN-1];
    scm_word_t       lat     [0:N_IN-1];
    scm_word_t       tmp     [0:N_TMP-1];
    scm_word_t       op_a;
    scm_word_t       op_b;
    scm_word_t       op_c;
    scm_word_t       mac_y;
    logic            mac_ovf;
    scm_word_t       neg_tref;
    scm_word_t       z_abs;
    logic            z_abs_ovf;
    scm_word_t       z_sel;
    logic            clamp_lo;
    logic            clamp_hi;
    logic            lo_hit;
    logic            hi_hit;
    scm_word_t       wr_val;
    logic            step_flag;
    logic            running;
    logic            last;
    logic            in_bridge;

    assign in_word[0]  = raw_bridge_reading;
    assign in_word[1]  = raw_temperature;
    assign in_word[2]  = calibration_reference_temp;
    assign in_word[3]  = bridge_gain;
    assign in_word[4]  = bridge_offset;
    assign in_word[5]  = gain_drift;
    assign in_word[6]  = offset_drift;
    assign in_word[7]  = second_order_gain_drift;
    assign in_word[8]  = second_order_offset_drift;
    assign in_word[9]  = second_order_bridge_term;
    assign in_word[10] = temp_gain;
    assign in_word[11] = temp_offset;
    assign in_word[12] = temperature_second_order_term;

    // inputs are latched at start so the operands stay still for a run
    genvar gi;
    generate
        for (gi = 0; gi < N_IN; gi = gi + 1) begin : g_lat
            scm_word_t lim_lo;
            scm_word_t lim_hi;
            assign lim_lo = (gi == 2) ? `SCM_TREF_MIN : `SCM_COEF_MIN;
            assign lim_hi = (gi == 2) ? `SCM_TREF_MAX : `SCM_COEF_MAX;
            always_ff @(posedge sys_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    lat[gi] <= `SCM_ZERO;
                end else if (start && state == scm_idle) begin
                    lat[gi] <= clamp_word(in_word[gi], lim_lo, lim_hi);
                end
            end
        end
    endgenerate

    assign running   = (state == scm_run);
    assign last      = (step == `SCM_STEP_LAST);
    assign in_bridge = (step < `SCM_STEP_TEMP);
    assign neg_tref  = -lat[2];
    // magnitude of -2^17 does not fit, so it saturates and is flagged
    assign z_abs_ovf = (tmp[10] == `SCM_MIN18);
    assign z_abs     = !tmp[10][17] ? tmp[10]
                     : (z_abs_ovf ? `SCM_MAX18 : -tmp[10]);
    assign z_sel = (curve == `SCM_CURVE_S) ? z_abs : tmp[10];

    // operand routing, one multiply-add per cycle
    always_comb begin
        op_a = `SCM_ONE;
        op_b = `SCM_ONE;
        op_c = `SCM_ZERO;
        case (step)
            5'h00: begin op_a = lat[1]; op_c = neg_tref; end
            5'h01: begin op_a = lat[7]; op_b = tmp[0]; op_c = lat[5]; end
            5'h02: begin op_a = tmp[0]; op_b = tmp[1]; end
            5'h03: begin op_a = tmp[2]; op_c = `SCM_ONE; end
            5'h04: begin op_a = lat[8]; op_b = tmp[0]; op_c = lat[6]; end
            5'h05: begin op_a = tmp[0]; op_b = tmp[4]; end
            5'h06: begin op_a = tmp[5]; op_c = lat[0]; end
            5'h07: begin op_a = tmp[6]; op_c = lat[4]; end
            5'h08: begin op_a = tmp[3]; op_b = tmp[7]; end
            5'h09: begin op_a = lat[3]; op_b = tmp[8]; end
            // offset added only in parabolic mode
            5'h0A: begin
                op_a = tmp[9];
                op_c = (curve == `SCM_CURVE_PAR) ? `SCM_ONE : `SCM_ZERO;
            end
            5'h0B: begin op_a = lat[9]; op_b = z_sel; end
            5'h0C: begin op_a = tmp[11]; op_c = `SCM_ONE; end
            5'h0D: begin
                op_a = tmp[10];
                op_b = tmp[12];
                op_c = (curve == `SCM_CURVE_S) ? `SCM_ONE : `SCM_ZERO;
            end
            5'h0E: begin op_a = lat[1]; op_c = lat[11]; end
            5'h0F: begin op_a = lat[10]; op_b = tmp[14]; end
            5'h10: begin op_a = tmp[15]; op_c = `SCM_ONE; end
            5'h11: begin op_a = lat[12]; op_b = tmp[16]; end
            5'h12: begin op_a = tmp[17]; op_c = `SCM_ONE; end
            5'h13: begin op_a = tmp[16]; op_b = tmp[18]; end
            default: begin op_a = `SCM_ZERO; end
        endcase
    end

    scm_mul_sat u_mac (
        .a   (op_a),
        .b   (op_b),
        .c   (op_c),
        .y   (mac_y),
        .ovf (mac_ovf)
    );

    assign clamp_lo = (step == 5'h10)
                   || (step == 5'h0A && curve == `SCM_CURVE_PAR)
                   || (step == 5'h0D) || (step == 5'h13);
    assign clamp_hi = (step == 5'h0D) || (step == 5'h13);
    assign lo_hit   = clamp_lo && mac_y[17];
    assign hi_hit   = clamp_hi && (mac_y > scm_word_t'(`SCM_U16_MAX));
    assign wr_val   = lo_hit ? `SCM_ZERO
                    : (hi_hit ? `SCM_U16_MAX : mac_y);
    // any bound hit during this step
    assign step_flag = mac_ovf | lo_hit | hi_hit
                     | ((step == 5'h0B) && curve && z_abs_ovf);

    assign next_state = (!running && start) ? scm_run
                      : ((running && last) ? scm_idle : state);
    assign next_step  = !running ? 5'h00 : (step + 5'h01);

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state <= scm_idle;
            step  <= 5'h00;
        end else begin
            state <= next_state;
            step  <= next_step;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            curve <= `SCM_CURVE_PAR;
        end else if (start && !running) begin
            curve <= curve_shape_select;
        end
    end

    // intermediates are not reset; each is written before it is read
    always_ff @(posedge sys_clk) begin
        if (running) begin
            tmp[step] <= wr_val;
        end
    end

    // flags gather, the run still completes
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            bflag <= 1'b0;
            tflag <= 1'b0;
        end else if (start && !running) begin
            bflag <= 1'b0;
            tflag <= 1'b0;
        end else if (running && step_flag) begin
            bflag <= bflag | in_bridge;
            tflag <= tflag | !in_bridge;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            busy          <= 1'b0;
            done          <= 1'b0;
            bridge_result <= 16'h0000;
            temp_result   <= 16'h0000;
            bridge_status <= 8'h00;
            temp_status   <= 8'h00;
        end else begin
            busy <= (next_state == scm_run);
            done <= running && last;
            if (running && last) begin
                bridge_result <= tmp[13][15:0];
                temp_result   <= wr_val[15:0];
                bridge_status <= {`SCM_STAT_PAD, bflag};
                temp_status   <= {`SCM_STAT_PAD, tflag | step_flag};
            end
        end
    end

    // helper for checking the temperature delta
    logic signed [18:0] dt_wide;
    scm_word_t          dt_exp;
    assign dt_wide = {lat[1][17], lat[1]} - {lat[2][17], lat[2]};
    assign dt_exp  = (dt_wide[18] == dt_wide[17]) ? dt_wide[17:0]
                   : (dt_wide[18] ? `SCM_MIN18 : `SCM_MAX18);

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    a_run_latency: assert property (
        (start && state == scm_idle) |-> ##21 done)
        else $error("done not seen 21 cycles after start");
    a_busy_hold: assert property (
        (start && state == scm_idle) |=> busy [*8])
        else $error("busy dropped early in a run");
    a_done_single: assert property (
        done |-> !busy ##1 !done)
        else $error("done longer than one cycle");
    a_delta_value: assert property (
        (running && step == 5'h00) |=> tmp[0] == $past(dt_exp))
        else $error("temperature delta wrong");
    a_gain_unity: assert property (
        (running && step == 5'h04 && tmp[1] == `SCM_ZERO)
        |-> tmp[3] == `SCM_ONE)
        else $error("gain factor not unity with zero drift");
    a_par_operand: assert property (
        (running && step == 5'h0B && !curve) |-> op_b == tmp[10])
        else $error("parabolic mode used wrong operand");
    a_s_abs: assert property (
        (running && step == 5'h0B && curve) |-> !op_b[17])
        else $error("S mode operand not absolute");
    a_par_nonneg: assert property (
        (running && step == 5'h0B && !curve) |-> !tmp[10][17])
        else $error("parabolic intermediate negative");
    a_temp_nonneg: assert property (
        (running && step == 5'h11) |-> !tmp[16][17])
        else $error("temperature intermediate negative");
    a_bridge_flag: assert property (
        (running && in_bridge && step_flag)
        |-> ##[1:21] (done && bridge_status[0]))
        else $error("bridge saturation not reported");
    a_temp_flag: assert property (
        (running && !in_bridge && step_flag)
        |-> ##[1:7] (done && temp_status[0]))
        else $error("temperature saturation not reported");

    c_par_run: cover property (done && !curve);
    c_s_run: cover property (done && curve);
    c_bridge_sat: cover property (done && bridge_status[0]);
    c_temp_sat: cover property (done && temp_status[0]);
endmodule
`default_nettype wire

// >>> scm_mul_sat.sv
// multiply, scale by 2^-15, saturate, add, saturate again
`timescale 1ns/1ps
`default_nettype none
`include "scm_cfg.svh"
module scm_mul_sat (
    input  wire scm_pkg::scm_word_t a,
    input  wire scm_pkg::scm_word_t b,
    input  wire scm_pkg::scm_word_t c,
    output scm_pkg::scm_word_t      y,
    output logic                    ovf
);
    import scm_pkg::*;

    logic signed [35:0] prod;
    logic signed [20:0] scaled;
    scm_word_t          prod_sat;
    logic               prod_ovf;
    logic signed [18:0] sum;
    logic               sum_ovf;

    // widen first so the full 36-bit signed product is kept
    assign prod = 36'(a) * 36'(b);
    assign scaled = prod[35:15];
    assign prod_ovf = (scaled[20:17] != {4{scaled[17]}});
    assign prod_sat = !prod_ovf ? scaled[17:0]
                    : (scaled[20] ? `SCM_MIN18 : `SCM_MAX18);
    assign sum = {prod_sat[17], prod_sat} + {c[17], c};
    assign sum_ovf = (sum[18] != sum[17]);
    assign y = !sum_ovf ? sum[17:0] : (sum[18] ? `SCM_MIN18 : `SCM_MAX18);
    assign ovf = prod_ovf | sum_ovf;
endmodule
`default_nettype wire

// >>> scm_pkg.sv
// types shared by the sensor correction datapath
package scm_pkg;
    typedef logic signed [17:0] scm_word_t;
    typedef enum logic [0:0] {
        scm_idle,
        scm_run
    } scm_state_t;
endpackage

// >>> tb_scm_core.sv
// self-checking bench for the sensor correction datapath
`timescale 1ns/1ps
`default_nettype none
module tb_scm_core;
    import scm_pkg::*;
    typedef struct {
        logic [15:0] b;
        logic [15:0] t;
        logic [7:0]  bs;
        logic [7:0]  ts;
        int          cyc;
    } scm_exp_t;
    localparam longint M   = 131071;
    localparam longint N   = -131072;
    localparam longint ONE = 32768;
    logic        sys_clk;
    logic        sys_rst;
    logic        start;
    logic        curve;
    scm_word_t   in_v [13];
    logic        busy;
    logic        done;
    logic [15:0] bridge_result;
    logic [15:0] temp_result;
    logic [7:0]  bridge_status;
    logic [7:0]  temp_status;
    scm_exp_t    q [$];
    scm_exp_t    e;
    int          cyc;
    int          seed;
    int          err_count;
    int          comparisons;
    bit          fl;
    bit          quiet;

    scm_core uut (
        .sys_clk                       (sys_clk),
        .sys_rst                       (sys_rst),
        .start                         (start),
        .curve_shape_select            (curve),
        .raw_bridge_reading            (in_v[0]),
        .raw_temperature               (in_v[1]),
        .calibration_reference_temp    (in_v[2]),
        .bridge_gain                   (in_v[3]),
        .bridge_offset                 (in_v[4]),
        .gain_drift                    (in_v[5]),
        .offset_drift                  (in_v[6]),
        .second_order_gain_drift       (in_v[7]),
        .second_order_offset_drift     (in_v[8]),
        .second_order_bridge_term      (in_v[9]),
        .temp_gain                     (in_v[10]),
        .temp_offset                   (in_v[11]),
        .temperature_second_order_term (in_v[12]),
        .busy                          (busy),
        .done                          (done),
        .bridge_result                 (bridge_result),
        .temp_result                   (temp_result),
        .bridge_status                 (bridge_status),
        .temp_status                   (temp_status)
    );

    // any clamp raises the flag, input range limits excepted
    function automatic longint sat(longint v, longint lo, longint hi);
        if (v < lo || v > hi) fl = 1'b1;
        return (v < lo) ? lo : (v > hi) ? hi : v;
    endfunction

    // floor shift, since negative products must round down
    function automatic longint st(longint a, longint b, longint c);
        return sat(sat((a * b) >>> 15, N, M) + c, N, M);
    endfunction

    function automatic longint cl(int i, longint m);
        longint x;
        x = longint'(in_v[i]);
        return (x < -m) ? -m : (x > m) ? m : x;
    endfunction

    task automatic predict(output scm_exp_t r);
        longint c [13];
        longint dt, k1, k2, m1, z, a, b, zt, t;
        for (int i = 0; i < 13; i++) c[i] = cl(i, (i == 2) ? 65535 : M);
        fl = 1'b0;
        dt = sat(c[1] - c[2], N, M);
        k1 = st(dt, st(c[7], dt, c[5]), ONE);
        k2 = sat(c[4] + st(dt, st(c[8], dt, c[6]), c[0]), N, M);
        m1 = sat((k1 * k2) >>> 15, N, M);
        if (!curve) begin
            z = sat(st(c[3], m1, ONE), 0, M);
            b = sat((z * st(c[9], z, ONE)) >>> 15, 0, 65535);
        end else begin
            z = sat((c[3] * m1) >>> 15, N, M);
            a = sat((z < 0) ? -z : z, N, M);
            b = sat(st(z, st(c[9], a, ONE), ONE), 0, 65535);
        end
        r.bs = {7'h00, fl};
        fl = 1'b0;
        zt = sat(st(c[10], sat(c[1] + c[11], N, M), ONE), 0, M);
        t = sat((zt * st(c[12], zt, ONE)) >>> 15, 0, 65535);
        r.ts = {7'h00, fl};
        r.b = b[15:0];
        r.t = t[15:0];
        r.cyc = cyc + 21;
    endtask

    // tame values sit near unity gain, wild ones span the full word
    task automatic set_inputs(bit big);
        for (int i = 0; i < 13; i++) begin
            in_v[i] = big ? scm_word_t'($random(seed))
                          : scm_word_t'($random(seed) % 2048);
            if (!big && (i == 3 || i == 10)) in_v[i] = in_v[i] + 18'h08000;
            // quiet runs clear the gain drift so the gain factor is unity
            if (quiet && (i == 5 || i == 7)) in_v[i] = '0;
        end
    endtask

    task automatic chk_flag(logic got, logic exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic chk_word(logic [15:0] got, logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic chk_zero();
        chk_flag(busy, 1'b0);
        chk_flag(done, 1'b0);
        chk_word(bridge_result, 16'h0000);
        chk_word(temp_result, 16'h0000);
        chk_word({bridge_status, temp_status}, 16'h0000);
    endtask

    task automatic start_run(bit cv, bit big);
        scm_exp_t r;
        @(negedge sys_clk);
        curve = cv;
        set_inputs(big);
        start = 1'b1;
        predict(r);
        q.push_back(r);
        @(negedge sys_clk);
        start = 1'b0;
    endtask

    // a start while busy must be dropped, its inputs with it
    task automatic run(bit cv, bit big);
        start_run(cv, big);
        repeat (4) @(negedge sys_clk);
        set_inputs(1'b1);
        curve = ~cv;
        start = 1'b1;
        @(negedge sys_clk);
        start = 1'b0;
        repeat (14) @(negedge sys_clk);
    endtask

    task automatic reset_mid();
        start_run(1'b0, 1'b0);
        repeat (6) @(negedge sys_clk);
        sys_rst = 1'b1;
        q.delete();
        repeat (2) @(negedge sys_clk);
        chk_zero();
        sys_rst = 1'b0;
    endtask

    task automatic summarize();
        $display("Comparisons: %0d mismatches: %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    always @(posedge sys_clk) begin
        cyc = cyc + 1;
        #1;
        if (!sys_rst) begin
            chk_flag(done, q.size() > 0 && q[0].cyc == cyc);
            chk_flag(busy, q.size() > 0 && cyc < q[0].cyc
                           && cyc >= q[0].cyc - 20);
            if (done === 1'b1 && q.size() > 0) begin
                e = q.pop_front();
                chk_word(bridge_result, e.b);
                chk_word(bridge_result, e.b);
                chk_word(temp_result, e.t);
                chk_word({8'h00, bridge_status}, {8'h00, e.bs});
                chk_word({8'h00, temp_status}, {8'h00, e.ts});
            end
        end
    end

    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    initial begin
        repeat (100000) @(posedge sys_clk);
        err_count++;
        summarize();
    end

    initial begin
        sys_rst = 1'b1;
        start = 1'b0;
        curve = 1'b0;
        seed = 40676;
        err_count = 0;
        comparisons = 0;
        cyc = 0;
        fl = 1'b0;
        foreach (in_v[i]) in_v[i] = '0;
        repeat (6) @(negedge sys_clk);
        chk_zero();
        sys_rst = 1'b0;
        for (int k = 0; k < 60; k++) begin
            quiet = (k < 2);
            run(k[0], k[1]);
            if (k == 30) reset_mid();
        end
        repeat (3) @(negedge sys_clk);
        chk_flag(q.size() == 0, 1'b1);
        summarize();
    end
endmodule
`default_nettype wire
